// ### bbf_defines.vh
// register map, command fields, opcodes, flag positions and cycle counts of the exec unit
`ifndef BBF_DEFINES_VH
`define BBF_DEFINES_VH

// apb byte addresses
`define BBF_ADDR_CMD 8'h00
`define BBF_ADDR_OFS 8'h04
`define BBF_ADDR_PC 8'h08
`define BBF_ADDR_FLAGS 8'h0c
`define BBF_ADDR_STATUS 8'h10
`define BBF_ADDR_SEL 8'h14
`define BBF_ADDR_DATA 8'h18

// command word fields
`define BBF_CMD_OP_MSB 5
`define BBF_CMD_OP_LSB 0
`define BBF_CMD_RD_LSB 8
`define BBF_CMD_BIT_MSB 18
`define BBF_CMD_BIT_LSB 16
`define BBF_CMD_IO_LSB 24
`define BBF_OFS_W 7

// selector register: index in low bits, space select bit
`define BBF_SEL_SPACE 8
`define BBF_SEL_W 9

// status register fields
`define BBF_STS_BUSY 0
`define BBF_STS_TAKEN 1
`define BBF_STS_ERR 2
`define BBF_STS_CYC_LSB 8

// opcodes
`define BBF_OP_BR_C1 6'h00
`define BBF_OP_BR_C0 6'h01
`define BBF_OP_BR_HS 6'h02
`define BBF_OP_BR_LO 6'h03
`define BBF_OP_BR_N1 6'h04
`define BBF_OP_BR_N0 6'h05
`define BBF_OP_BR_GE 6'h06
`define BBF_OP_BR_LT 6'h07
`define BBF_OP_BR_H1 6'h08
`define BBF_OP_BR_H0 6'h09
`define BBF_OP_BR_V0 6'h0a
`define BBF_OP_BR_I1 6'h0b
`define BBF_OP_BR_I0 6'h0c
`define BBF_OP_IO_SET 6'h10
`define BBF_OP_IO_CLR 6'h11
`define BBF_OP_LSL 6'h12
`define BBF_OP_LSR 6'h13
`define BBF_OP_ROL 6'h14
`define BBF_OP_ROR 6'h15
`define BBF_OP_ASR 6'h16
`define BBF_OP_SWAP 6'h17
`define BBF_OP_BST 6'h18
`define BBF_OP_BLD 6'h19
`define BBF_OP_FLAG_SET 6'h1a
`define BBF_OP_FLAG_CLR 6'h1b

// flag register bit positions
`define BBF_FLG_C 0
`define BBF_FLG_Z 1
`define BBF_FLG_N 2
`define BBF_FLG_V 3
`define BBF_FLG_S 4
`define BBF_FLG_H 5
`define BBF_FLG_T 6
`define BBF_FLG_I 7

// reset values
`define BBF_FLAGS_RST 8'h00
`define BBF_CMD_RST 32'h00000000
`define BBF_OFS_RST 7'h00
`define BBF_SEL_RST 9'h000

// instruction cycle counts
`define BBF_CYC_ONE 2'h1
`define BBF_CYC_BR_TAKEN 2'h2
`define BBF_CYC_IO 2'h2

`endif

// ### bbf_mem.v
// single-port memory with registered read data
`timescale 1ns/1ns
module bbf_mem #(
  parameter W = 8,
  parameter D = 32,
  parameter AW = 5
) (
  input wire clk_sys,
  input wire rst_n,
  input wire ce,
  input wire we,
  input wire [AW-1:0] addr,
  input wire [W-1:0] wdata,
  output reg [W-1:0] rdata_ff
);
  reg [W-1:0] mem [0:D-1];

  // array is not reset; contents are loaded by software
  always @(posedge clk_sys) begin
    if (ce && we) begin
      mem[addr] <= wdata;
    end
  end

  // read during write returns the old word
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= {W{1'b0}};
    end else if (ce) begin
      rdata_ff <= mem[addr];
    end
  end
endmodule // bbf_mem

// ### bbf_exec_unit.v
// branch, bit, shift and flag execution unit with apb register access
// How it works
// - carry branches: go to pc+k+1 when carry matches the form, 1 or 2 cycles
// - negative-flag branches jump on n set or clear, target pc+k+1
// - signed branches test n xor v: ge on zero, less on one
// - half-carry branches jump when h is set or cleared per form
// - no-overflow branch jumps only while v is zero
// - irq branches jump when global irq flag is on or off per form
// - io bit raise/lower force one io bit, keep flags, take two cycles
// - left shift fills bit 0 with zero, updates z c n v, one cycle
// - right shift fills bit 7 with zero, updates z c n v, one cycle
// - rotate left: old carry into bit 0, old bit 7 into carry
// - rotate right: old carry into bit 7, old bit 0 into carry
// - arithmetic right shift keeps bit 7, updates z c n v, one cycle
// - nibble swap exchanges halves in one cycle, flags untouched
// - bit store copies register bit to t; bit load copies t back
// - single-flag set and clear touch only the chosen flag, one cycle
// - global irq on sets i, global irq off clears i, one cycle
// - sign flag set and clear use the single-flag ops with bit 4, one cycle, only s
`timescale 1ns/1ns
`include "bbf_defines.vh"
module bbf_exec_unit #(
  parameter PC_W = 16,
  parameter RF_DEPTH = 32,
  parameter RF_AW = 5,
  parameter IO_DEPTH = 64,
  parameter IO_AW = 6
) (
  input wire clk_sys,
  input wire rst_n,
  input wire ce,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  output wire busy,
  output wire [7:0] flags_out,
  output wire [PC_W-1:0] pc_out
);
  localparam ST_IDLE = 4'b0001;
  localparam ST_READ = 4'b0010;
  localparam ST_EXEC = 4'b0100;
  localparam ST_HOLD = 4'b1000;

  reg [3:0] state_ff;
  reg [3:0] nxt_state;
  reg [PC_W-1:0] pc_ff;
  reg [7:0] flags_ff;
  reg [31:0] cmd_ff;
  reg [`BBF_OFS_W-1:0] ofs_ff;
  reg [`BBF_SEL_W-1:0] sel_ff;
  reg [1:0] cnt_ff;
  reg [1:0] last_cyc_ff;
  reg taken_ff;
  reg err_ff;
  reg [1:0] ph_ff;
  reg [31:0] prdata_ff;

  wire [7:0] rf_rdata;
  wire [7:0] io_rdata;

  // ---------------- apb slave ----------------
  wire acc = psel & penable;
  wire a_cmd = (paddr == `BBF_ADDR_CMD);
  wire a_ofs = (paddr == `BBF_ADDR_OFS);
  wire a_pc = (paddr == `BBF_ADDR_PC);
  wire a_flg = (paddr == `BBF_ADDR_FLAGS);
  wire a_sts = (paddr == `BBF_ADDR_STATUS);
  wire a_sel = (paddr == `BBF_ADDR_SEL);
  wire a_data = (paddr == `BBF_ADDR_DATA);
  wire mapped = a_cmd | a_ofs | a_pc | a_flg | a_sts | a_sel | a_data;
  wire idle = (state_ff == ST_IDLE);
  // everything but status waits for the current instruction to retire
  wire stall = ~idle & ~a_sts;
  // data window needs one more cycle for the registered memory read
  wire [1:0] need = a_data ? 2'h2 : 2'h1;

  assign pready = acc & ce & ~stall & (ph_ff == need);
  assign pslverr = pready & ~mapped;
  assign prdata = prdata_ff;

  wire wr_fire = pready & pwrite & mapped;
  wire sel_io = sel_ff[`BBF_SEL_SPACE];

  reg [31:0] rd_mux;
  always @* begin
    rd_mux = 32'h00000000;
    if (a_cmd) begin
      rd_mux = cmd_ff;
    end else if (a_ofs) begin
      rd_mux = {{(32-`BBF_OFS_W){1'b0}}, ofs_ff};
    end else if (a_pc) begin
      rd_mux = {{(32-PC_W){1'b0}}, pc_ff};
    end else if (a_flg) begin
      rd_mux = {24'h000000, flags_ff};
    end else if (a_sts) begin
      rd_mux[`BBF_STS_BUSY] = ~idle;
      rd_mux[`BBF_STS_TAKEN] = taken_ff;
      rd_mux[`BBF_STS_ERR] = err_ff;
      rd_mux[`BBF_STS_CYC_LSB +: 2] = last_cyc_ff;
    end else if (a_sel) begin
      rd_mux = {{(32-`BBF_SEL_W){1'b0}}, sel_ff};
    end
  end

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ph_ff <= 2'h0;
      prdata_ff <= 32'h00000000;
    end else if (ce) begin
      if (pready) begin
        ph_ff <= 2'h0;
      end else if (acc && !stall) begin
        ph_ff <= ph_ff + 2'h1;
      end
      if (acc && !stall && ph_ff == 2'h0 && !a_data) begin
        prdata_ff <= rd_mux;
      end else if (acc && a_data && ph_ff == 2'h1) begin
        prdata_ff <= {24'h000000, (sel_io ? io_rdata : rf_rdata)};
      end
    end
  end

  // ---------------- instruction decode and execute ----------------
  wire [5:0] op = cmd_ff[`BBF_CMD_OP_MSB:`BBF_CMD_OP_LSB];
  wire [2:0] bsel = cmd_ff[`BBF_CMD_BIT_MSB:`BBF_CMD_BIT_LSB];
  wire [RF_AW-1:0] rd_idx = cmd_ff[`BBF_CMD_RD_LSB +: RF_AW];
  wire [IO_AW-1:0] io_idx = cmd_ff[`BBF_CMD_IO_LSB +: IO_AW];
  wire [7:0] bmask = 8'h01 << bsel;
  wire f_c = flags_ff[`BBF_FLG_C];
  wire f_n = flags_ff[`BBF_FLG_N];
  wire f_v = flags_ff[`BBF_FLG_V];
  wire f_h = flags_ff[`BBF_FLG_H];
  wire f_t = flags_ff[`BBF_FLG_T];
  wire f_i = flags_ff[`BBF_FLG_I];
  wire [PC_W-1:0] k_ext = {{(PC_W-`BBF_OFS_W){ofs_ff[`BBF_OFS_W-1]}}, ofs_ff};
  wire [PC_W-1:0] pc_next = pc_ff + {{(PC_W-1){1'b0}}, 1'b1};
  // offset is a signed word displacement from the following instruction
  wire [PC_W-1:0] pc_target = pc_next + k_ext;

  reg is_br;
  reg cond;
  reg is_shift;
  reg [7:0] res;
  reg new_c;
  reg we_rf;
  reg we_io;
  reg bad;
  reg [7:0] nxt_flags;
  reg [1:0] cyc;

  always @* begin
    is_br = 1'b0;
    cond = 1'b0;
    is_shift = 1'b0;
    res = rf_rdata;
    new_c = f_c;
    we_rf = 1'b0;
    we_io = 1'b0;
    bad = 1'b0;
    nxt_flags = flags_ff;
    cyc = `BBF_CYC_ONE;
    case (op)
      `BBF_OP_BR_C1, `BBF_OP_BR_LO: begin
        is_br = 1'b1;
        cond = f_c;
      end
      `BBF_OP_BR_C0, `BBF_OP_BR_HS: begin
        is_br = 1'b1;
        cond = ~f_c;
      end
      `BBF_OP_BR_N1: begin
        is_br = 1'b1;
        cond = f_n;
      end
      `BBF_OP_BR_N0: begin
        is_br = 1'b1;
        cond = ~f_n;
      end
      `BBF_OP_BR_GE: begin
        is_br = 1'b1;
        cond = ~(f_n ^ f_v);
      end
      `BBF_OP_BR_LT: begin
        is_br = 1'b1;
        cond = f_n ^ f_v;
      end
      `BBF_OP_BR_H1: begin
        is_br = 1'b1;
        cond = f_h;
      end
      `BBF_OP_BR_H0: begin
        is_br = 1'b1;
        cond = ~f_h;
      end
      `BBF_OP_BR_V0: begin
        is_br = 1'b1;
        cond = ~f_v;
      end
      `BBF_OP_BR_I1: begin
        is_br = 1'b1;
        cond = f_i;
      end
      `BBF_OP_BR_I0: begin
        is_br = 1'b1;
        cond = ~f_i;
      end
      `BBF_OP_IO_SET: begin
        res = io_rdata | bmask;
        we_io = 1'b1;
        cyc = `BBF_CYC_IO;
      end
      `BBF_OP_IO_CLR: begin
        res = io_rdata & ~bmask;
        we_io = 1'b1;
        cyc = `BBF_CYC_IO;
      end
      `BBF_OP_LSL: begin
        res = {rf_rdata[6:0], 1'b0};
        new_c = rf_rdata[7];
        is_shift = 1'b1;
      end
      `BBF_OP_LSR: begin
        res = {1'b0, rf_rdata[7:1]};
        new_c = rf_rdata[0];
        is_shift = 1'b1;
      end
      `BBF_OP_ROL: begin
        res = {rf_rdata[6:0], f_c};
        new_c = rf_rdata[7];
        is_shift = 1'b1;
      end
      `BBF_OP_ROR: begin
        res = {f_c, rf_rdata[7:1]};
        new_c = rf_rdata[0];
        is_shift = 1'b1;
      end
      `BBF_OP_ASR: begin
        res = {rf_rdata[7], rf_rdata[7:1]};
        new_c = rf_rdata[0];
        is_shift = 1'b1;
      end
      `BBF_OP_SWAP: begin
        res = {rf_rdata[3:0], rf_rdata[7:4]};
        we_rf = 1'b1;
      end
      `BBF_OP_BST: begin
        nxt_flags[`BBF_FLG_T] = rf_rdata[bsel];
      end
      `BBF_OP_BLD: begin
        res = f_t ? (rf_rdata | bmask) : (rf_rdata & ~bmask);
        we_rf = 1'b1;
      end
      `BBF_OP_FLAG_SET: begin
        // bit field picks the flag: c z n v s h t i, so irq on and sign raise live here
        nxt_flags = flags_ff | bmask;
      end
      `BBF_OP_FLAG_CLR: begin
        nxt_flags = flags_ff & ~bmask;
      end
      default: begin
        // unknown opcode retires as a one-cycle no-op and raises the error bit
        bad = 1'b1;
      end
    endcase
    if (is_shift) begin
      we_rf = 1'b1;
      nxt_flags[`BBF_FLG_C] = new_c;
      nxt_flags[`BBF_FLG_Z] = (res == 8'h00);
      nxt_flags[`BBF_FLG_N] = res[7];
      nxt_flags[`BBF_FLG_V] = res[7] ^ new_c;
    end
    if (is_br && cond) begin
      cyc = `BBF_CYC_BR_TAKEN;
    end
  end

  // ---------------- memories ----------------
  wire ex = (state_ff == ST_EXEC);
  wire data_wr = idle & wr_fire & a_data;
  wire [RF_AW-1:0] rf_addr = idle ? sel_ff[RF_AW-1:0] : rd_idx;
  wire [IO_AW-1:0] io_addr = idle ? sel_ff[IO_AW-1:0] : io_idx;
  wire rf_we = (ex & we_rf) | (data_wr & ~sel_io);
  wire io_we = (ex & we_io) | (data_wr & sel_io);
  wire [7:0] mem_wdata = idle ? pwdata[7:0] : res;

  bbf_mem #(.W(8), .D(RF_DEPTH), .AW(RF_AW)) u_rf (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .ce(ce),
    .we(rf_we),
    .addr(rf_addr),
    .wdata(mem_wdata),
    .rdata_ff(rf_rdata)
  );

  bbf_mem #(.W(8), .D(IO_DEPTH), .AW(IO_AW)) u_io (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .ce(ce),
    .we(io_we),
    .addr(io_addr),
    .wdata(mem_wdata),
    .rdata_ff(io_rdata)
  );

  // ---------------- sequencer ----------------
  always @* begin
    case (state_ff)
      ST_IDLE: nxt_state = (wr_fire && a_cmd) ? ST_READ : ST_IDLE;
      ST_READ: nxt_state = ST_EXEC;
      ST_EXEC: nxt_state = (cyc == `BBF_CYC_ONE) ? ST_IDLE : ST_HOLD;
      ST_HOLD: nxt_state = (cnt_ff == 2'h1) ? ST_IDLE : ST_HOLD;
      default: nxt_state = ST_IDLE;
    endcase
  end

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= ST_IDLE;
      pc_ff <= {PC_W{1'b0}};
      flags_ff <= `BBF_FLAGS_RST;
      cmd_ff <= `BBF_CMD_RST;
      ofs_ff <= `BBF_OFS_RST;
      sel_ff <= `BBF_SEL_RST;
      cnt_ff <= 2'h0;
      last_cyc_ff <= 2'h0;
      taken_ff <= 1'b0;
      err_ff <= 1'b0;
    end else if (ce) begin
      state_ff <= nxt_state;
      if (ex) begin
        // untaken branches and all other ops fall through to the next word
        pc_ff <= (is_br && cond) ? pc_target : pc_next;
        flags_ff <= nxt_flags;
        cnt_ff <= cyc - 2'h1;
        last_cyc_ff <= cyc;
        taken_ff <= is_br & cond;
        err_ff <= bad;
      end else if (state_ff == ST_HOLD) begin
        cnt_ff <= cnt_ff - 2'h1;
      end else if (wr_fire) begin
        if (a_cmd) begin
          cmd_ff <= pwdata;
        end
        if (a_ofs) begin
          ofs_ff <= pwdata[`BBF_OFS_W-1:0];
        end
        if (a_pc) begin
          pc_ff <= pwdata[PC_W-1:0];
        end
        if (a_flg) begin
          flags_ff <= pwdata[7:0];
        end
        if (a_sel) begin
          sel_ff <= pwdata[`BBF_SEL_W-1:0];
        end
      end
    end
  end

  assign busy = ~idle;
  assign flags_out = flags_ff;
  assign pc_out = pc_ff;
endmodule // bbf_exec_unit

// ### bbf_exec_checker.sv
// port assertions for the branch, bit, shift and flag exec unit
`timescale 1ns/1ns
module bbf_exec_checker #(
  parameter PC_W = 16
) (
  input wire clk_sys,
  input wire rst_n,
  input wire ce,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire busy,
  input wire [7:0] flags_out,
  input wire [PC_W-1:0] pc_out
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  wire acc = psel && penable && pready && pwrite;
  wire wr_cmd = acc && !pslverr && paddr == 8'h00;
  wire wr_pc = acc && paddr == 8'h08;
  wire wr_flg = acc && paddr == 8'h0c;
  sequence s_cmd;
    wr_cmd;
  endsequence
  // read and exec cycles, then an optional hold for two-cycle instructions
  sequence s_run;
    busy [*2] ##1 (!busy or busy ##1 !busy);
  endsequence
  AST_RUN_LEN: assert property (s_cmd |=> s_run)
    else $error("instruction length not one or two cycles");
  AST_BUSY_SRC: assert property ($rose(busy) |-> $past(wr_cmd))
    else $error("busy rose without a command write");
  AST_PC_SRC: assert property ($changed(pc_out) |-> $past(busy) || $past(wr_pc))
    else $error("pc changed outside an instruction");
  AST_FLG_SRC: assert property ($changed(flags_out) |-> $past(busy) || $past(wr_flg))
    else $error("flags changed outside an instruction");
  AST_STALL: assert property (busy && psel && penable && paddr != 8'h10 |-> !pready)
    else $error("access answered while busy");
  AST_RDY_PULSE: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  AST_RDY_ACC: assert property (pready |-> psel && penable)
    else $error("pready outside an access phase");
  AST_ERR_RDY: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  AST_CE_HOLD: assert property (!ce |-> !pready)
    else $error("pready while clock enable low");
endmodule // bbf_exec_checker

bind bbf_exec_unit bbf_exec_checker #(.PC_W(PC_W)) u_chk (
  .clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .busy(busy), .flags_out(flags_out), .pc_out(pc_out));

// ### bbf_exec_unit_tb.sv
// self-checking bench for the exec unit over apb
`timescale 1ns/1ns
`include "bbf_defines.vh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_total++; \
  $display("Error t=%0t got=%h exp=%h", $time, g, e); end end
module bbf_exec_unit_tb;
  logic clk_sys = 1'b0, rst_n = 1'b0, ce = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00, f, d;
  logic [31:0] pwdata = 32'h0, rdat;
  logic [6:0] k;
  logic [8:0] sh;
  logic rerr, t;
  logic [7:0] fl [3] = '{8'h00, 8'hff, 8'h04};
  logic [7:0] dv [3] = '{8'h81, 8'h00, 8'h40};
  wire [31:0] prdata;
  wire pready, pslverr, busy;
  wire [7:0] flags_out;
  wire [15:0] pc_out;
  int err_total = 0, n_tests = 0, cyc = 0;
  bbf_exec_unit u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .busy(busy), .flags_out(flags_out), .pc_out(pc_out));
  always #20 clk_sys = ~clk_sys;
  task stop_test;
    $display("comparisons=%0d mismatches=%0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc > 20000) begin
      err_total++;
      stop_test();
    end
  end
  // pready is read at the rising edge before that edge's updates land; the cycle timeout ends a hang
  task automatic apb(input bit w, input [7:0] a, input [31:0] v);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input [7:0] a, input [31:0] v);
    apb(1'b1, a, v);
  endtask
  task rdc(input [7:0] a, input [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rdat, e)
  endtask
  task setm(input [8:0] s, input [7:0] v);
    wr(`BBF_ADDR_SEL, s);
    wr(`BBF_ADDR_DATA, v);
  endtask
  task automatic run(input [31:0] c);
    wr(`BBF_ADDR_CMD, c);
    do begin
      apb(1'b0, `BBF_ADDR_STATUS, 32'h0);
    end while (rdat[0] !== 1'b0);
  endtask
  function automatic bit tk(input int op, input [7:0] g);
    case (op)
      0, 3: return g[0];
      1, 2: return !g[0];
      4: return g[2];
      5: return !g[2];
      6: return !(g[2] ^ g[3]);
      7: return g[2] ^ g[3];
      8: return g[5];
      9: return !g[5];
      10: return !g[3];
      11: return g[7];
      default: return !g[7];
    endcase
  endfunction
  function automatic [8:0] shx(input int op, input [7:0] v, input c);
    case (op)
      18: return {v, 1'b0};
      19: return {v[0], 1'b0, v[7:1]};
      20: return {v, c};
      21: return {v[0], c, v[7:1]};
      default: return {v[0], v[7], v[7:1]};
    endcase
  endfunction
  initial begin
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    `CHK({pc_out, flags_out}, 24'h0)
    rdc(`BBF_ADDR_STATUS, 32'h0);
    for (int op = 0; op < 13; op++) begin
      for (int i = 0; i < 3; i++) begin
        f = fl[i];
        k = i[0] ? 7'h3f : 7'h40;
        t = tk(op, f);
        wr(`BBF_ADDR_PC, 32'h0100);
        wr(`BBF_ADDR_FLAGS, f);
        wr(`BBF_ADDR_OFS, k);
        run(op);
        `CHK(rdat[9:0], {t ? 2'h2 : 2'h1, 6'h0, t, 1'b0})
        rdc(`BBF_ADDR_PC, t ? 32'h0101 + {{25{k[6]}}, k} : 32'h0101);
        rdc(`BBF_ADDR_FLAGS, f);
      end
    end
    for (int op = 18; op < 23; op++) begin
      for (int i = 0; i < 3; i++) begin
        d = dv[i];
        f = 8'hae | i[0];
        sh = shx(op, d, f[0]);
        setm(9'h005, d);
        wr(`BBF_ADDR_FLAGS, f);
        run(32'h500 | op);
        rdc(`BBF_ADDR_DATA, sh[7:0]);
        rdc(`BBF_ADDR_FLAGS, {f[7:4], sh[7] ^ sh[8], sh[7], sh[7:0] == 0, sh[8]});
      end
    end
    setm(9'h005, 8'h3c);
    wr(`BBF_ADDR_FLAGS, 8'h5a);
    run(32'h517);
    rdc(`BBF_ADDR_DATA, 8'hc3);
    rdc(`BBF_ADDR_FLAGS, 8'h5a);
    setm(9'h005, 8'h08);
    wr(`BBF_ADDR_FLAGS, 8'h00);
    run(32'h30518);
    rdc(`BBF_ADDR_FLAGS, 8'h40);
    run(32'h60519);
    rdc(`BBF_ADDR_DATA, 8'h48);
    for (int b = 0; b < 8; b++) begin
      wr(`BBF_ADDR_FLAGS, 32'h0);
      run(32'h1a | b << 16);
      rdc(`BBF_ADDR_FLAGS, 1 << b);
      wr(`BBF_ADDR_FLAGS, 32'hff);
      run(32'h1b | b << 16);
      rdc(`BBF_ADDR_FLAGS, 8'hff ^ (1 << b));
    end
    // unknown opcode: one-cycle no-op with the error bit, flags kept
    run(32'h3f);
    `CHK(rdat[9:0], 10'h104)
    rdc(`BBF_ADDR_FLAGS, 8'h7f);
    setm(9'h12a, 8'h5a);
    wr(`BBF_ADDR_FLAGS, 8'h3c);
    run(32'h2a000010);
    `CHK(rdat[9:8], 2'h2)
    rdc(`BBF_ADDR_DATA, 8'h5b);
    run(32'h2a060011);
    rdc(`BBF_ADDR_DATA, 8'h1b);
    rdc(`BBF_ADDR_FLAGS, 8'h3c);
    // a two-cycle op followed at once by a data read exercises the busy stall
    wr(`BBF_ADDR_CMD, 32'h2a060010);
    rdc(`BBF_ADDR_DATA, 8'h5b);
    apb(1'b0, 8'h1c, 32'h0);
    `CHK(rerr, 1'b1)
    wr(`BBF_ADDR_PC, 32'h1234);
    // a frozen clock enable only stretches the transfer
    fork
      rdc(`BBF_ADDR_PC, 32'h1234);
      begin
        ce <= 1'b0;
        repeat (4) @(posedge clk_sys);
        ce <= 1'b1;
      end
    join
    stop_test();
  end
endmodule // bbf_exec_unit_tb
